// File: testbench/steer_properties.sv
/* Checker on the shared steering lines.
   Assumes tb_top wires it beside the interface. */
`timescale 1ns/10ps
module steer_properties (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RST_N,
    // Driver enables
    input wire logic cpu_addr_oe,
    input wire logic far_addr_oe,
    input wire logic cpu_field_oe,
    input wire logic far_field_oe,
    input wire logic cpu_word_oe,
    input wire logic far_word_oe,
    // CPU state lines
    input wire logic data_direction_select_n,
    input wire logic dma_active,
    input wire logic [3:0] bus_use
);
    // Direction level at which the CPU owns the word lines
    localparam logic CPU_LVL = 1'b1;
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    property p_addr_one; !(cpu_addr_oe && far_addr_oe); endproperty
    a_addr_one: assert property (p_addr_one) else $error("two address drivers");
    property p_field_one; !(cpu_field_oe && far_field_oe); endproperty
    a_field_one: assert property (p_field_one) else $error("two field drivers");
    property p_word_one; !(cpu_word_oe && far_word_oe); endproperty
    a_word_one: assert property (p_word_one) else $error("two word drivers");
    property p_cpu_dir; cpu_word_oe |-> data_direction_select_n == CPU_LVL; endproperty
    a_cpu_dir: assert property (p_cpu_dir) else $error("cpu drives off direction");
    property p_mem_dir; far_word_oe |-> data_direction_select_n != CPU_LVL; endproperty
    a_mem_dir: assert property (p_mem_dir) else $error("memory drives off direction");
    property p_dma_addr; dma_active |-> far_addr_oe && !cpu_addr_oe; endproperty
    a_dma_addr: assert property (p_dma_addr) else $error("break address owner");
    property p_cpu_addr; !dma_active |-> cpu_addr_oe; endproperty
    a_cpu_addr: assert property (p_cpu_addr) else $error("cpu address owner");
    property p_dma_field; dma_active |-> far_field_oe && !cpu_field_oe; endproperty
    a_dma_field: assert property (p_dma_field) else $error("break field owner");
    property p_dma_word; dma_active |-> !cpu_word_oe; endproperty
    a_dma_word: assert property (p_dma_word) else $error("cpu writes in break");
    property p_use; $onehot(bus_use); endproperty
    a_use: assert property (p_use) else $error("bus use not one-hot");
endmodule

// File: testbench/tb_top.sv
/* Bench joining the CPU end and far end over the shared lines.
   Assumes wired-AND resolution with lines idle high. */
`timescale 1ns/10ps
module tb_top;
    import bus_steer_pkg::*;
    // Clock, reset and stimulus
    logic CLOCK = 1'b0;
    logic RST_N = 1'b0;
    logic tp = 1'b0, lp = 1'b0, dc = 1'b0, wr = 1'b0, ext = 1'b0;
    logic [1:0] ms = 2'h0;
    logic [11:0] na = 12'h0000, da = 12'h0000, bd = 12'h0000, md = 12'h0000;
    logic [2:0] ef = 3'h0, df = 3'h0;
    // Observed results
    logic [11:0] ca, rw, sa, sw;
    logic [2:0] cf, sf;
    logic own;
    logic [3:0] bu;
    int errors = 0;
    int n_checks = 0;
    steer_bus_if bus ();
    // Wired-AND of every enabled driver
    assign bus.cycle_address_low_n = (bus.cpu_addr_oe ? bus.cpu_addr_out : ADDR_IDLE)
        & (bus.far_addr_oe ? bus.far_addr_out : ADDR_IDLE);
    assign bus.extended_field_address_n = (bus.cpu_field_oe ? bus.cpu_field_out : FIELD_IDLE)
        & (bus.far_field_oe ? bus.far_field_out : FIELD_IDLE);
    assign bus.memory_word_lines_n = (bus.cpu_word_oe ? bus.cpu_word_out : DATA_IDLE)
        & (bus.far_word_oe ? bus.far_word_out : DATA_IDLE);
    cpu_steer cpu_steer_i (.CLOCK(CLOCK), .RST_N(RST_N), .BUS(bus), .FOURTH_TIME_PULSE(tp),
        .LOAD_ADDRESS_PULSE(lp), .DMA_CYCLE(dc), .CPU_WRITE(wr), .MACHINE_STATE(ms),
        .EXT_PRESENT(ext), .NEXT_ADDRESS(na), .BUFFER_DATA(bd), .CYCLE_ADDRESS(ca),
        .CYCLE_FIELD(cf), .READ_WORD(rw), .DMA_OWNS(own), .BUS_USE(bu));
    far_steer far_steer_i (.CLOCK(CLOCK), .RST_N(RST_N), .BUS(bus), .EXT_PRESENT(ext),
        .EXT_FIELD(ef), .DMA_ADDR(da), .DMA_FIELD(df), .MEM_READ_DATA(md),
        .SEEN_ADDR(sa), .SEEN_FIELD(sf), .SEEN_WORD(sw));
    steer_properties steer_properties_i (.CLOCK(CLOCK), .RST_N(RST_N),
        .cpu_addr_oe(bus.cpu_addr_oe), .far_addr_oe(bus.far_addr_oe),
        .cpu_field_oe(bus.cpu_field_oe), .far_field_oe(bus.far_field_oe),
        .cpu_word_oe(bus.cpu_word_oe), .far_word_oe(bus.far_word_oe),
        .data_direction_select_n(bus.data_direction_select_n),
        .dma_active(bus.dma_active), .bus_use(bus.bus_use));
    // Free-running clock
    initial begin
        forever #(CLOCK_NS / 2) CLOCK = ~CLOCK;
    end
    // Compare one result
    task chk(input logic [11:0] got, input logic [11:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Wait falling edges
    task wt(input int n);
        repeat (n) @(negedge CLOCK);
    endtask
    // One-cycle timing pulse, then settle
    task pulse(input logic load);
        if (load) lp = 1'b1;
        else tp = 1'b1;
        wt(1);
        lp = 1'b0;
        tp = 1'b0;
        wt(2);
    endtask
    // CPU address with extension field, held after input moves
    task t_cpu_addr;
        ext = 1'b1;
        ef = 3'h5;
        na = 12'ha5c;
        pulse(1'b0);
        na = 12'h3c1;
        wt(2);
        chk(ca, 12'ha5c);
        chk(bus.cycle_address_low_n, ~12'ha5c);
        chk(sa, 12'ha5c);
        chk({9'h0, cf}, 12'h005);
        chk({9'h0, bus.extended_field_address_n}, 12'h002);
    endtask
    // No extension control: field reads zero
    task t_no_ext;
        ext = 1'b0;
        pulse(1'b0);
        chk(ca, 12'h3c1);
        chk({9'h0, cf}, 12'h000);
        chk({9'h0, bus.extended_field_address_n}, 12'h007);
    endtask
    // Break cycle with a refused CPU write
    task t_dma;
        dc = 1'b1;
        da = 12'h7e2;
        df = 3'h6;
        wr = 1'b1;
        bd = 12'h111;
        md = 12'h9b4;
        pulse(1'b1);
        dc = 1'b0;
        chk({11'h0, own}, 12'h001);
        chk(sa, 12'h7e2);
        chk(ca, 12'h3c1);
        chk({9'h0, cf}, 12'h006);
        chk({9'h0, sf}, 12'h006);
        chk(rw, 12'h9b4);
        chk(bus.memory_word_lines_n, ~12'h9b4);
        wr = 1'b0;
        pulse(1'b0);
        chk({11'h0, own}, 12'h000);
    endtask
    // Word lines both ways
    task t_write;
        wr = 1'b1;
        bd = 12'hc3a;
        wt(3);
        chk(sw, 12'hc3a);
        chk(bus.memory_word_lines_n, ~12'hc3a);
        wr = 1'b0;
        md = 12'h5e7;
        wt(3);
        chk(rw, 12'h5e7);
        chk(bus.memory_word_lines_n, ~12'h5e7);
    endtask
    // Every data bus use
    task t_use;
        for (int i = 0; i < 4; i++) begin
            ms = i[1:0];
            wt(2);
            chk({8'h0, bu}, 12'h001 << i);
        end
    endtask
    // Reset in mid-run: every driver released, registers cleared
    task t_reset;
        RST_N = 1'b0;
        wt(2);
        chk(bus.cycle_address_low_n, ADDR_IDLE);
        chk(bus.memory_word_lines_n, DATA_IDLE);
        chk({8'h0, bu}, 12'h001);
        RST_N = 1'b1;
        wt(1);
        chk(ca, 12'h000);
        chk({11'h0, own}, 12'h000);
    endtask
    // Verdict and end of run
    task final_report;
        if (errors == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Main sequence
    initial begin
        wt(12);
        RST_N = 1'b1;
        wt(1);
        t_cpu_addr;
        t_no_ext;
        t_dma;
        t_write;
        t_use;
        t_reset;
        final_report;
    end
    // Watchdog
    initial begin
        #100000;
        errors++;
        final_report;
    end
endmodule

// File: verilog/bus_steer_pkg.sv
/*
 * Shared constants for the backplane memory path steering ends.
 * Assumes a single 20 MHz clock and active-low bus lines resolved by the bench.
 */
package bus_steer_pkg;
    // Line widths
    localparam int ADDR_W = 12;        // Low-order address lines
    localparam int FIELD_W = 3;        // Extended field lines
    localparam int DATA_W = 12;        // Memory word and shared data lines
    // Idle (released) level of an active-low line: high reads as zero
    localparam logic [ADDR_W-1:0] ADDR_IDLE = 12'h0fff;
    localparam logic [FIELD_W-1:0] FIELD_IDLE = 3'h7;
    localparam logic [DATA_W-1:0] DATA_IDLE = 12'h0fff;
    // Clock period in ns
    localparam int CLOCK_NS = 50;
    // Data bus use selectors
    typedef enum logic [3:0] {
        USE_EXCHANGE = 4'b0001,        // Peripheral and CPU exchange
        USE_DMA_IN   = 4'b0010,        // Data input from DMA device
        USE_PANEL    = 4'b0100,        // Front-panel register monitor
        USE_PRIORITY = 4'b1000         // Data-break priority resolution
    } bus_use_e;
endpackage

// File: verilog/cpu_steer.sv
/*
 * CPU end of the memory path: address, field, word-line and data-bus use steering.
 * Assumes the far end keeps its drivers released as directed, and the bench resolves wires.
 */
`timescale 1ns/10ps
module cpu_steer
    import bus_steer_pkg::*;
(
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RST_N,
    // Bus side
    steer_bus_if.cpu_end BUS,
    // Timing from the CPU timing generator
    input wire logic FOURTH_TIME_PULSE,
    input wire logic LOAD_ADDRESS_PULSE,
    // Machine state
    input wire logic DMA_CYCLE,
    input wire logic CPU_WRITE,
    input wire logic [1:0] MACHINE_STATE,
    input wire logic EXT_PRESENT,
    // CPU data
    input wire logic [ADDR_W-1:0] NEXT_ADDRESS,
    input wire logic [DATA_W-1:0] BUFFER_DATA,
    // Observed results
    output logic [ADDR_W-1:0] CYCLE_ADDRESS,
    output logic [FIELD_W-1:0] CYCLE_FIELD,
    output logic [DATA_W-1:0] READ_WORD,
    output logic DMA_OWNS,
    output logic [3:0] BUS_USE
);
    // Address register held for the whole cycle
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] next_addr;
    // Break ownership latched with the address
    logic dma;
    logic next_dma;
    // Direction: 1 means CPU drives the word lines
    logic cpu_drive;
    logic next_cpu_drive;
    // Memory buffer register
    logic [DATA_W-1:0] memory_buffer_register;
    logic [DATA_W-1:0] next_buffer;
    // Data bus use, one-hot
    bus_use_e use_sel;
    bus_use_e next_use;
    // Captured read word and field
    logic [DATA_W-1:0] next_read;
    logic [FIELD_W-1:0] next_field;
    // Load strobe from either timing pulse
    logic load_edge;

    // Address and owner: next values, moved only by a timing pulse
    always_comb begin
        // Either timing source opens a new memory cycle
        load_edge = FOURTH_TIME_PULSE || LOAD_ADDRESS_PULSE;
        // Hold by default so the lines stay static through the cycle
        next_addr = addr;
        next_dma = dma;
        if (load_edge) begin
            // Address and owner move only here, then hold
            next_addr = NEXT_ADDRESS;
            // Break ownership sampled with the address
            next_dma = DMA_CYCLE;
        end
    end

    // Address and owner registers
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            // Reset: clear the owner so the CPU takes the address lines once reset ends
            addr <= '0;
            dma <= 1'b0;
        end else begin
            // Held or newly loaded values
            addr <= next_addr;
            dma <= next_dma;
        end
    end

    // Direction and buffer: next values
    always_comb begin
        // Write intent sets direction, refused in a break
        // Incoming owner is used, so a write beside a break load never drives
        next_cpu_drive = CPU_WRITE && !next_dma;
        // Buffer loads on write, otherwise keeps its word
        if (CPU_WRITE) begin
            next_buffer = BUFFER_DATA;
        end else begin
            next_buffer = memory_buffer_register;
        end
    end

    // Direction and buffer registers
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            // Reset: clear direction so the memory side takes the word lines once reset ends
            cpu_drive <= 1'b0;
            memory_buffer_register <= '0;
        end else begin
            // Follow write intent one cycle later
            cpu_drive <= next_cpu_drive;
            memory_buffer_register <= next_buffer;
        end
    end

    // Data bus use: next value from machine state
    always_comb begin
        case (MACHINE_STATE)
            2'h0: begin
                // Peripheral and CPU exchange
                next_use = USE_EXCHANGE;
            end
            2'h1: begin
                // Input word from a break device
                next_use = USE_DMA_IN;
            end
            2'h2: begin
                // Panel register monitor
                next_use = USE_PANEL;
            end
            2'h3: begin
                // Break priority resolution
                next_use = USE_PRIORITY;
            end
            default: begin
                // Unknown state falls back to exchange
                next_use = USE_EXCHANGE;
            end
        endcase
    end

    // Data bus use register
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            // Reset: exchange use
            use_sel <= USE_EXCHANGE;
        end else begin
            // Follow machine state one cycle later
            use_sel <= next_use;
        end
    end

    // Capture: next read word and field from the resolved lines
    always_comb begin
        if (cpu_drive) begin
            // Own write on the lines: keep the last memory word
            next_read = READ_WORD;
        end else begin
            // Memory drives: decode the active-low word
            next_read = ~BUS.memory_word_lines_n;
        end
        // Field as resolved on the lines, active high
        next_field = ~BUS.extended_field_address_n;
    end

    // Capture registers
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            // Reset: nothing read yet
            READ_WORD <= '0;
            CYCLE_FIELD <= '0;
        end else begin
            // Registered copies, one cycle behind the lines
            READ_WORD <= next_read;
            CYCLE_FIELD <= next_field;
        end
    end

    // Bus drivers, all active low; each enable drops in reset so that
    // no end fights another while registers are still settling
    always_comb begin
        // Low address: CPU unless a break owns the cycle
        BUS.cpu_addr_oe = RST_N && !dma;
        BUS.cpu_addr_out = ~addr;
        // Pull-up stand-in reads as zero when no extension
        BUS.cpu_field_oe = RST_N && !EXT_PRESENT && !dma;
        BUS.cpu_field_out = FIELD_IDLE;
        // Word lines: buffer register while the CPU writes
        BUS.cpu_word_oe = RST_N && cpu_drive;
        BUS.cpu_word_out = ~memory_buffer_register;
        // Direction high while the CPU drives, low while memory drives
        BUS.data_direction_select_n = cpu_drive;
        // State lines for the far end
        BUS.dma_active = dma;
        BUS.bus_use = use_sel;
    end

    // Observed outputs
    // Address register as loaded, also during a break
    assign CYCLE_ADDRESS = addr;
    // Owner of the current cycle
    assign DMA_OWNS = dma;
    // Data bus use, one-hot
    assign BUS_USE = use_sel;
endmodule

// File: verilog/far_steer.sv
/*
 * Far end: memory, extension control, DMA device and peripheral drivers.
 * Assumes the CPU end drives direction, DMA state and address timing.
 */
`timescale 1ns/10ps
module far_steer
    import bus_steer_pkg::*;
(
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RST_N,
    // Bus side
    steer_bus_if.far_end BUS,
    // User side
    input wire logic EXT_PRESENT,
    input wire logic [FIELD_W-1:0] EXT_FIELD,
    input wire logic [ADDR_W-1:0] DMA_ADDR,
    input wire logic [FIELD_W-1:0] DMA_FIELD,
    input wire logic [DATA_W-1:0] MEM_READ_DATA,
    output logic [ADDR_W-1:0] SEEN_ADDR,
    output logic [FIELD_W-1:0] SEEN_FIELD,
    output logic [DATA_W-1:0] SEEN_WORD
);
    // Next values of the registered bus copies, active high
    logic [ADDR_W-1:0] next_addr;
    logic [FIELD_W-1:0] next_field;
    logic [DATA_W-1:0] next_word;

    // Drivers: released unless selected, active-low encoding
    always_comb begin
        BUS.far_addr_oe = RST_N && BUS.dma_active;
        BUS.far_addr_out = ~DMA_ADDR;
        BUS.far_field_oe = RST_N && (BUS.dma_active || EXT_PRESENT);
        BUS.far_field_out = BUS.dma_active ? ~DMA_FIELD : ~EXT_FIELD;
        BUS.far_word_oe = RST_N && !BUS.data_direction_select_n;
        BUS.far_word_out = ~MEM_READ_DATA;
    end

    // Monitor: decode lines as peripherals and DMA devices do
    always_comb begin
        next_addr = ~BUS.cycle_address_low_n;
        next_field = ~BUS.extended_field_address_n;
        next_word = ~BUS.memory_word_lines_n;
    end

    // Register monitored values
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            SEEN_ADDR <= '0;
            SEEN_FIELD <= '0;
            SEEN_WORD <= '0;
        end else begin
            SEEN_ADDR <= next_addr;
            SEEN_FIELD <= next_field;
            SEEN_WORD <= next_word;
        end
    end
endmodule

// File: verilog/steer_bus_if.sv
/*
 * Shared lines between the CPU end and the peripheral end.
 * Assumes the bench resolves each wire from the enables (wired-AND, high idle).
 */
`timescale 1ns/10ps
interface steer_bus_if;
    import bus_steer_pkg::*;
    // CPU end drives
    logic [ADDR_W-1:0] cpu_addr_out;
    logic cpu_addr_oe;
    logic [FIELD_W-1:0] cpu_field_out;
    logic cpu_field_oe;
    logic [DATA_W-1:0] cpu_word_out;
    logic cpu_word_oe;
    logic data_direction_select_n;
    logic dma_active;
    logic [3:0] bus_use;
    // Far end drives
    logic [ADDR_W-1:0] far_addr_out;
    logic far_addr_oe;
    logic [FIELD_W-1:0] far_field_out;
    logic far_field_oe;
    logic [DATA_W-1:0] far_word_out;
    logic far_word_oe;
    // Resolved levels, supplied by the bench
    logic [ADDR_W-1:0] cycle_address_low_n;
    logic [FIELD_W-1:0] extended_field_address_n;
    logic [DATA_W-1:0] memory_word_lines_n;
    modport cpu_end (
        output cpu_addr_out, cpu_addr_oe, cpu_field_out, cpu_field_oe,
        output cpu_word_out, cpu_word_oe, data_direction_select_n, dma_active, bus_use,
        input cycle_address_low_n, extended_field_address_n, memory_word_lines_n
    );
    modport far_end (
        output far_addr_out, far_addr_oe, far_field_out, far_field_oe,
        output far_word_out, far_word_oe,
        input data_direction_select_n, dma_active, bus_use,
        input cycle_address_low_n, extended_field_address_n, memory_word_lines_n
    );
endinterface
